// [inc/ssc_consts.svh]
// Register offsets, field positions and reset values of the serial shift clock select block
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH

// Register byte offsets
`define SSC_OFF_CTRL      8'h00
`define SSC_OFF_PINPOS    8'h04
`define SSC_OFF_DATA      8'h08
`define SSC_OFF_COUNT     8'h0c
`define SSC_OFF_PORT      8'h10
`define SSC_OFF_FIFO      8'h14

// Control register fields
`define SSC_CTRL_TOGGLE   0
`define SSC_CTRL_STROBE   1
`define SSC_CTRL_CS_LO    2
`define SSC_CTRL_CS_HI    3
`define SSC_CTRL_WM_LO    4
`define SSC_CTRL_WM_HI    5
`define SSC_CTRL_RESET    7'h00

// Pin position and port control fields
`define SSC_POS_BIT       0
`define SSC_PORT_CLK_VAL  0
`define SSC_PORT_CLK_DIR  1
`define SSC_PORT_DO_DIR   2

// Pin index inside a three-pin group
`define SSC_PIN_DI        0
`define SSC_PIN_DO        1
`define SSC_PIN_CLK       2

// Reset values and FIFO read layout
`define SSC_DATA_RESET    8'h00
`define SSC_COUNT_RESET   4'h0
`define SSC_COUNT_LAST    4'hf
`define SSC_FIFO_VALID    8
`define SSC_FIFO_WIDTH    8
`define SSC_FIFO_DEPTH    32

`endif

// [inc/ssc_pkg.sv]
// Types shared by the serial shift clock select block
package ssc_pkg;

    typedef enum logic [1:0] {
        SSC_CS_STROBE  = 2'b00,
        SSC_CS_TIMER   = 2'b01,
        SSC_CS_EXT_POS = 2'b10,
        SSC_CS_EXT_NEG = 2'b11
    } ssc_clk_src_t;

    typedef enum logic [1:0] {
        SSC_WM_NONE  = 2'b00,
        SSC_WM_THREE = 2'b01,
        SSC_WM_TWO_A = 2'b10,
        SSC_WM_TWO_B = 2'b11
    } ssc_wire_mode_t;

endpackage

// [inc/ssc_stream_if.sv]
// Valid/ready stream between the shift logic and its FIFO
`timescale 1ns/10ps
`default_nettype none

interface ssc_stream_if #(
    parameter int WIDTH = 8
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface

`default_nettype wire

// [sim/ssc_partner.sv]
// Behavioural external serial master driving clock and data pins
`timescale 1ns/10ps
`default_nettype none

module ssc_partner (
    // Link pins
    output var logic sclk_o,
    output var logic sdi_o
);
    initial begin
        sclk_o = 1'b0;
        sdi_o  = 1'b0;
    end

    // Clock stands still at its idle level between frames
    task automatic idle(input logic neg);
        #10 sclk_o = neg;
    endtask

    // Data leads the sampling edge by a quarter period, 400 ns bit time
    task automatic send(input logic neg, input logic [7:0] b);
        // Keep pin changes off the sampling clock edge
        #10;
        for (int i = 7; i >= 0; i--) begin
            sdi_o = b[i];
            #100 sclk_o = ~neg;
            #200 sclk_o = neg;
            #100;
        end
        // Released line shows the inverse, so a stale bit cannot pass
        sdi_o = ~b[0];
    endtask
endmodule

`default_nettype wire

// [sim/test_ssc_top.sv]
// Self-checking bench of the serial shift clock select block
`timescale 1ns/10ps
`include "ssc_consts.svh"
`default_nettype none

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
    $display("mismatch %0t %h %h", $time, a, b); end end

module test_ssc_top;
    logic        clk_i;
    logic        rst_i;
    logic        wb_cyc;
    logic        wb_we;
    logic [7:0]  wb_adr;
    logic [31:0] wb_dat;
    logic [31:0] rd;
    logic [31:0] r;
    logic        ack;
    logic        tm;
    logic        di;
    logic        pa_di;
    logic        use_p;
    logic [2:0]  pb_in, pb_out, pb_oe_n, pa_in, pa_out, pa_oe_n;
    wire logic   sclk;
    wire logic   sdi;
    int          miscompares;
    int          checked;

    // Wire levels: a released pb clock pin follows the far side, a released pa clock pin reads low
    assign pb_in = {pb_oe_n[2] ? sclk : pb_out[2], pb_out[1], use_p ? sdi : di};
    assign pa_in = {pa_oe_n[2] ? 1'b0 : pa_out[2], pa_out[1], pa_di};

    ssc_top u_ssc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_cyc),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'h1), .wb_dat_i(wb_dat),
        .wb_dat_o(rd), .wb_ack_o(ack), .timer_match_i(tm), .pb_in_i(pb_in),
        .pb_out_o(pb_out), .pb_oe_n_o(pb_oe_n), .pa_in_i(pa_in), .pa_out_o(pa_out),
        .pa_oe_n_o(pa_oe_n));
    ssc_partner u_ssc_partner (.sclk_o(sclk), .sdi_o(sdi));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic end_of_test();
        if (miscompares == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_we  <= w;
        wb_adr <= a;
        wb_dat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            end_of_test();
        end
        r = rd;
        wb_cyc <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        `CHK(r, e)
    endtask

    // Synced data-in settles before the match pulse
    task automatic tpulse(input logic v);
        di <= v;
        wait_clk(3);
        tm <= 1'b1;
        @(posedge clk_i);
        tm <= 1'b0;
    endtask

    task automatic t_reset();
        for (int i = 0; i < 28; i += 4) chk_rd(i[7:0], 32'h0);
        `CHK({pb_oe_n, pa_oe_n}, 6'h3f)
    endtask

    task automatic t_strobe();
        wr(`SSC_OFF_CTRL, 32'h10);
        wr(`SSC_OFF_PORT, 32'h04);
        wr(`SSC_OFF_DATA, 32'h40);
        di <= 1'b1;
        wait_clk(4);
        chk_rd(`SSC_OFF_DATA, 32'h40);
        wr(`SSC_OFF_CTRL, 32'h12);
        wait_clk(1);
        `CHK({pb_oe_n[1], pb_out[1]}, 2'b01)
        chk_rd(`SSC_OFF_DATA, 32'h81);
        chk_rd(`SSC_OFF_COUNT, 32'h1);
        chk_rd(`SSC_OFF_CTRL, 32'h10);
    endtask

    task automatic t_timer();
        wr(`SSC_OFF_CTRL, 32'h04);
        wr(`SSC_OFF_COUNT, 32'he);
        wr(`SSC_OFF_DATA, 32'h0);
        repeat (3) tpulse(1'b1);
        chk_rd(`SSC_OFF_COUNT, 32'h1);
        wr(`SSC_OFF_CTRL, 32'h06);
        tpulse(1'b1);
        chk_rd(`SSC_OFF_DATA, 32'h0f);
        chk_rd(`SSC_OFF_FIFO, 32'h103);
    endtask

    // Fill until the full FIFO stalls the counter at 15, then drain
    task automatic t_fifo();
        wr(`SSC_OFF_CTRL, 32'h04);
        wr(`SSC_OFF_COUNT, 32'h0);
        for (int n = 0; n < 33 * 16; n++) tpulse(n[0]);
        chk_rd(`SSC_OFF_COUNT, 32'hf);
        chk_rd(`SSC_OFF_DATA, 32'haa);
        for (int n = 0; n < 32; n++) chk_rd(`SSC_OFF_FIFO, 32'h155);
        chk_rd(`SSC_OFF_FIFO, 32'h0);
    endtask

    // Wire mode stays off; positive then negative shift edge
    task automatic t_ext();
        logic [7:0] b;
        use_p <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            b = m ? 8'h3c : 8'ha5;
            wr(`SSC_OFF_CTRL, m ? 32'h0c : 32'h08);
            u_ssc_partner.idle(m[0]);
            wait_clk(6);
            wr(`SSC_OFF_COUNT, 32'h0);
            u_ssc_partner.send(m[0], b);
            wait_clk(8);
            chk_rd(`SSC_OFF_DATA, {24'h0, b});
            chk_rd(`SSC_OFF_COUNT, 32'h0);
            chk_rd(`SSC_OFF_FIFO, {23'h0, 1'b1, b});
        end
        use_p <= 1'b0;
    endtask

    // Master clocking by toggle writes; pin edges shift but do not count
    task automatic t_toggle();
        wr(`SSC_OFF_CTRL, 32'h0a);
        wr(`SSC_OFF_PORT, 32'h02);
        wr(`SSC_OFF_COUNT, 32'h0);
        repeat (3) begin
            wr(`SSC_OFF_CTRL, 32'h0b);
            wait_clk(6);
        end
        chk_rd(`SSC_OFF_COUNT, 32'h3);
        chk_rd(`SSC_OFF_PORT, 32'h3);
        `CHK({pb_oe_n[2], pb_out[2]}, 2'b01)
        wr(`SSC_OFF_PORT, 32'h01);
        wait_clk(1);
        `CHK(pb_oe_n[2], 1'b1)
    endtask

    task automatic t_pos();
        wr(`SSC_OFF_PINPOS, 32'hff);
        chk_rd(`SSC_OFF_PINPOS, 32'h01);
        wr(`SSC_OFF_PORT, 32'h02);
        wr(`SSC_OFF_CTRL, 32'h0);
        wr(`SSC_OFF_DATA, 32'h0);
        di    <= 1'b0;
        pa_di <= 1'b1;
        wait_clk(4);
        `CHK({pa_oe_n[2], pa_out[2], pb_oe_n, pb_out}, 8'h38)
        // Input flips one cycle before the strobe edge; the older sample must win
        pa_di <= 1'b0;
        wr(`SSC_OFF_CTRL, 32'h02);
        chk_rd(`SSC_OFF_DATA, 32'h1);
    endtask

    initial begin
        rst_i       = 1'b1;
        wb_cyc      = 1'b0;
        wb_we       = 1'b0;
        wb_adr      = 8'h00;
        wb_dat      = 32'h0;
        tm          = 1'b0;
        di          = 1'b0;
        pa_di       = 1'b0;
        use_p       = 1'b0;
        miscompares = 0;
        checked     = 0;
        wait_clk(2);
        rst_i <= 1'b0;
        t_reset();
        t_strobe();
        t_timer();
        t_fifo();
        t_ext();
        t_toggle();
        t_pos();
        end_of_test();
    end
endmodule

`default_nettype wire

// [verilog/ssc_fifo.sv]
// Synchronous FIFO for received bytes
`timescale 1ns/10ps
`default_nettype none

module ssc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic     clk_i,
    input  wire logic     rst_i,
    // Streams
    ssc_stream_if.sink    in_s,
    ssc_stream_if.source  out_s
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
            $error("FIFO depth must be a power of two and width at least one");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    // Extra pointer bit tells full from empty
    assign empty       = (wr_ptr == rd_ptr);
    assign full        = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign push        = in_s.valid && !full;
    assign pop         = out_s.ready && !empty;
    assign in_s.ready  = !full;
    assign out_s.valid = !empty;
    assign out_s.data  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_s.data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
        end else if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_ptr <= '0;
        end else if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule

`default_nettype wire

// [verilog/ssc_top.sv]
// Serial shift register clock select, strobe, toggle and pin position logic
//
// Contract
// - External clock: output latched on opposite edge
// - Strobe or timer source: output latch transparent
// - Source 00: only strobe writes clock both
// - Source 01: timer match clocks register, counter
// - External: shift chosen edge, count both edges
// - External with strobe set: toggle writes count
// - Strobe shifts, counts, updates output same cycle
// - Strobe shifts in previous cycle's data input
// - Strobe and toggle bits read as zero
// - Toggle inverts clock port value, direction gates pin
// - Edge counter is four bits wide
// - Position bit picks pin group, rest reads zero
// - Counter takes external clock without wire mode
//
// The address map and register access over Wishbone were chosen for this implementation.
`timescale 1ns/10ps
`include "ssc_consts.svh"
`default_nettype none

module ssc_top #(
    parameter int FIFO_WIDTH = `SSC_FIFO_WIDTH,
    parameter int FIFO_DEPTH = `SSC_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Timer compare match pulse
    input  wire logic        timer_match_i,
    // Default pin group
    input  wire logic [2:0]  pb_in_i,
    output logic      [2:0]  pb_out_o,
    output logic      [2:0]  pb_oe_n_o,
    // Alternate pin group
    input  wire logic [2:0]  pa_in_i,
    output logic      [2:0]  pa_out_o,
    output logic      [2:0]  pa_oe_n_o
);
    generate
        if (FIFO_WIDTH != 8 || FIFO_DEPTH < 2) begin : g_bad
            $error("FIFO must be eight bits wide and at least two deep");
        end
    endgenerate

    function automatic logic ssc_hit(input logic [7:0] adr, input logic [7:0] off);
        return adr[7:2] == off[7:2];
    endfunction

    ssc_stream_if #(.WIDTH(FIFO_WIDTH)) push_s ();
    ssc_stream_if #(.WIDTH(FIFO_WIDTH)) pop_s ();

    ssc_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .in_s  (push_s),
        .out_s (pop_s)
    );

    // Control state
    logic [7:1]             ctrl_q;
    logic                   pos_q;
    logic [7:0]             shift_data;
    logic [3:0]             edge_count;
    logic                   clk_port;
    logic                   clk_dir;
    logic                   do_dir;
    logic                   do_q;
    logic                   di_prev;
    logic                   rd_valid_q;
    // Pin synchronisers, first stage read by second only
    logic [5:0]             pin_s1;
    logic [5:0]             pin_s2;
    logic                   clk_prev;
    // Decoded bus and clocking terms
    logic                   req;
    logic                   wr;
    logic                   rd_fifo;
    logic                   strobe_pulse;
    logic                   toggle_pulse;
    ssc_pkg::ssc_clk_src_t  clk_src;
    ssc_pkg::ssc_wire_mode_t wire_mode;
    logic [2:0]             pin_in;
    logic                   di_sel;
    logic                   clk_sel;
    logic                   ext_rise;
    logic                   ext_fall;
    logic                   shift_edge;
    logic                   latch_edge;
    logic                   raw_shift;
    logic                   raw_count;
    logic                   hold;
    logic                   shift_evt;
    logic                   count_evt;
    logic                   in_bit;
    logic [7:0]             next_shift;
    logic                   next_do;
    logic                   next_clk_port;
    logic                   next_clk_dir;
    logic                   next_do_dir;
    logic                   next_pos;
    logic [2:0]             next_pin_out;
    logic [2:0]             next_pin_oe_n;
    logic [31:0]            next_rdata;

    // Bus: one wait state, write and pop take effect on the ack edge
    assign req     = wb_cyc_i && wb_stb_i;
    assign wr      = req && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign rd_fifo = req && !wb_we_i && wb_ack_o && ssc_hit(wb_adr_i, `SSC_OFF_FIFO);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req && !wb_ack_o;
        end
    end

    // Pulses decoded from write data, not from stored bits, so they cannot stick
    assign strobe_pulse = wr && ssc_hit(wb_adr_i, `SSC_OFF_CTRL)
                          && wb_dat_i[`SSC_CTRL_STROBE];
    assign toggle_pulse = wr && ssc_hit(wb_adr_i, `SSC_OFF_CTRL)
                          && wb_dat_i[`SSC_CTRL_TOGGLE];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `SSC_CTRL_RESET;
        end else if (wr && ssc_hit(wb_adr_i, `SSC_OFF_CTRL)) begin
            ctrl_q <= wb_dat_i[7:1];
        end
    end

    assign clk_src   = ssc_pkg::ssc_clk_src_t'(ctrl_q[`SSC_CTRL_CS_HI:`SSC_CTRL_CS_LO]);
    assign wire_mode = ssc_pkg::ssc_wire_mode_t'(ctrl_q[`SSC_CTRL_WM_HI:`SSC_CTRL_WM_LO]);

    // Both groups synchronised so a position change sees settled levels
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1   <= '0;
            pin_s2   <= '0;
            clk_prev <= 1'b0;
            di_prev  <= 1'b0;
        end else begin
            pin_s1   <= {pa_in_i, pb_in_i};
            pin_s2   <= pin_s1;
            clk_prev <= clk_sel;
            di_prev  <= di_sel;
        end
    end

    assign pin_in   = pos_q ? pin_s2[5:3] : pin_s2[2:0];
    assign di_sel   = pin_in[`SSC_PIN_DI];
    assign clk_sel  = pin_in[`SSC_PIN_CLK];
    assign ext_rise = clk_sel && !clk_prev;
    assign ext_fall = !clk_sel && clk_prev;

    // Edge choice for shifting and its opposite for the output latch
    assign shift_edge = (clk_src == ssc_pkg::SSC_CS_EXT_NEG) ? ext_fall : ext_rise;
    assign latch_edge = (clk_src == ssc_pkg::SSC_CS_EXT_NEG) ? ext_rise : ext_fall;

    always_comb begin
        case (clk_src)
            ssc_pkg::SSC_CS_STROBE: begin
                raw_shift = strobe_pulse;
                raw_count = strobe_pulse;
            end
            ssc_pkg::SSC_CS_TIMER: begin
                raw_shift = timer_match_i;
                raw_count = timer_match_i;
            end
            ssc_pkg::SSC_CS_EXT_POS, ssc_pkg::SSC_CS_EXT_NEG: begin
                raw_shift = shift_edge;
                // Wire mode plays no part here; inputs count unless the strobe bit selects toggle writes
                raw_count = ctrl_q[`SSC_CTRL_STROBE] ? toggle_pulse
                                                     : (ext_rise || ext_fall);
            end
            default: begin
                raw_shift = 1'b0;
                raw_count = 1'b0;
            end
        endcase
    end

    // Full FIFO freezes clocking before the byte that would be lost
    assign hold      = (edge_count == `SSC_COUNT_LAST) && !push_s.ready;
    assign shift_evt = raw_shift && !hold;
    assign count_evt = raw_count && !hold;

    // Strobe takes the input seen one cycle before the write
    assign in_bit = (clk_src == ssc_pkg::SSC_CS_STROBE) ? di_prev : di_sel;

    always_comb begin
        next_shift = shift_data;
        if (wr && ssc_hit(wb_adr_i, `SSC_OFF_DATA)) begin
            next_shift = wb_dat_i[7:0];
        end else if (shift_evt) begin
            next_shift = {shift_data[6:0], in_bit};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_data <= `SSC_DATA_RESET;
        end else begin
            shift_data <= next_shift;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            edge_count <= `SSC_COUNT_RESET;
        end else if (wr && ssc_hit(wb_adr_i, `SSC_OFF_COUNT)) begin
            edge_count <= wb_dat_i[3:0];
        end else if (count_evt) begin
            edge_count <= edge_count + 4'h1;
        end
    end

    // Byte completes when the counter wraps
    assign push_s.valid = count_evt && (edge_count == `SSC_COUNT_LAST);
    assign push_s.data  = next_shift;
    assign pop_s.ready  = rd_fifo && rd_valid_q;

    // Latch: transparent for internal sources, edge-held for external
    always_comb begin
        if (clk_src == ssc_pkg::SSC_CS_EXT_POS || clk_src == ssc_pkg::SSC_CS_EXT_NEG) begin
            next_do = latch_edge ? shift_data[7] : do_q;
        end else begin
            next_do = next_shift[7];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            do_q <= 1'b0;
        end else begin
            do_q <= next_do;
        end
    end

    // Port value toggles regardless of direction
    always_comb begin
        next_clk_port = clk_port;
        next_clk_dir  = clk_dir;
        next_do_dir   = do_dir;
        if (wr && ssc_hit(wb_adr_i, `SSC_OFF_PORT)) begin
            next_clk_port = wb_dat_i[`SSC_PORT_CLK_VAL];
            next_clk_dir  = wb_dat_i[`SSC_PORT_CLK_DIR];
            next_do_dir   = wb_dat_i[`SSC_PORT_DO_DIR];
        end
        if (toggle_pulse) begin
            next_clk_port = ~clk_port;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_port <= 1'b0;
            clk_dir  <= 1'b0;
            do_dir   <= 1'b0;
        end else begin
            clk_port <= next_clk_port;
            clk_dir  <= next_clk_dir;
            do_dir   <= next_do_dir;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pos_q <= 1'b0;
        end else begin
            pos_q <= next_pos;
        end
    end

    assign next_pos = (wr && ssc_hit(wb_adr_i, `SSC_OFF_PINPOS)) ? wb_dat_i[`SSC_POS_BIT]
                                                                  : pos_q;

    // Pin drive computed from next values, except the DO enable, which uses the stored wire mode and lags a control write by one cycle
    always_comb begin
        next_pin_out                = '0;
        next_pin_oe_n               = 3'h7;
        next_pin_out[`SSC_PIN_CLK]  = next_clk_port;
        next_pin_oe_n[`SSC_PIN_CLK] = ~next_clk_dir;
        next_pin_out[`SSC_PIN_DO]   = next_do;
        next_pin_oe_n[`SSC_PIN_DO]  = ~(next_do_dir && (wire_mode != ssc_pkg::SSC_WM_NONE));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pb_out_o  <= '0;
            pb_oe_n_o <= 3'h7;
            pa_out_o  <= '0;
            pa_oe_n_o <= 3'h7;
        end else begin
            pb_out_o  <= next_pos ? 3'h0 : next_pin_out;
            pb_oe_n_o <= next_pos ? 3'h7 : next_pin_oe_n;
            pa_out_o  <= next_pos ? next_pin_out : 3'h0;
            pa_oe_n_o <= next_pos ? next_pin_oe_n : 3'h7;
        end
    end

    // Read data is captured on the edge that raises ack
    always_comb begin
        next_rdata = '0;
        if (ssc_hit(wb_adr_i, `SSC_OFF_CTRL)) begin
            next_rdata[7:2] = ctrl_q[7:2];
        end else if (ssc_hit(wb_adr_i, `SSC_OFF_PINPOS)) begin
            next_rdata[`SSC_POS_BIT] = pos_q;
        end else if (ssc_hit(wb_adr_i, `SSC_OFF_DATA)) begin
            next_rdata[7:0] = shift_data;
        end else if (ssc_hit(wb_adr_i, `SSC_OFF_COUNT)) begin
            next_rdata[3:0] = edge_count;
        end else if (ssc_hit(wb_adr_i, `SSC_OFF_PORT)) begin
            next_rdata[`SSC_PORT_CLK_VAL] = clk_port;
            next_rdata[`SSC_PORT_CLK_DIR] = clk_dir;
            next_rdata[`SSC_PORT_DO_DIR]  = do_dir;
        end else if (ssc_hit(wb_adr_i, `SSC_OFF_FIFO)) begin
            next_rdata[7:0]             = pop_s.valid ? pop_s.data : 8'h00;
            next_rdata[`SSC_FIFO_VALID] = pop_s.valid;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o   <= '0;
            rd_valid_q <= 1'b0;
        end else if (req && !wb_we_i && !wb_ack_o) begin
            wb_dat_o   <= next_rdata;
            rd_valid_q <= pop_s.valid;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_EXT_LATCH: assert property (
        (clk_src[1] && latch_edge) |=> (do_q == $past(shift_data[7])))
        else $error("external output latch missed opposite edge");

    AST_TRANSPARENT: assert property (
        (!clk_src[1] ##1 !clk_src[1]) |-> (do_q == shift_data[7]))
        else $error("output latch not transparent");

    AST_IDLE_NO_CLOCK: assert property (
        (clk_src == ssc_pkg::SSC_CS_STROBE && !strobe_pulse && !wr)
        |=> ($stable(shift_data) && $stable(edge_count)))
        else $error("shift logic clocked without strobe");

    AST_TIMER_COUNT: assert property (
        (clk_src == ssc_pkg::SSC_CS_TIMER && timer_match_i && !hold && !wr)
        |=> (edge_count == $past(edge_count) + 4'h1))
        else $error("timer match did not advance counter");

    AST_EXT_BOTH_EDGES: assert property (
        (clk_src[1] && !ctrl_q[`SSC_CTRL_STROBE] && (ext_rise || ext_fall) && !hold && !wr)
        |=> (edge_count == $past(edge_count) + 4'h1))
        else $error("external edge not counted");

    AST_EXT_TOGGLE_ONLY: assert property (
        (clk_src[1] && ctrl_q[`SSC_CTRL_STROBE] && !toggle_pulse && !wr)
        |=> $stable(edge_count))
        else $error("counter moved without toggle write");

    AST_STROBE_SHIFT: assert property (
        (clk_src == ssc_pkg::SSC_CS_STROBE && strobe_pulse && !hold)
        |=> (shift_data[7:1] == $past(shift_data[6:0])
             && edge_count == $past(edge_count) + 4'h1 && do_q == shift_data[7]))
        else $error("strobe did not shift and count");

    AST_STROBE_INPUT: assert property (
        (clk_src == ssc_pkg::SSC_CS_STROBE && strobe_pulse && !hold)
        |=> (shift_data[0] == $past(di_prev)))
        else $error("strobe shifted wrong input sample");

    AST_READ_ZERO: assert property (
        (wb_ack_o && !wb_we_i && ssc_hit(wb_adr_i, `SSC_OFF_CTRL))
        |-> (wb_dat_o[1:0] == 2'b00))
        else $error("strobe or toggle bit read as one");

    AST_TOGGLE: assert property (
        toggle_pulse |=> (clk_port != $past(clk_port)))
        else $error("toggle write did not invert clock port");

    AST_PIN_GROUP: assert property (
        (pos_q ##1 pos_q) |-> (pb_oe_n_o == 3'h7 && pa_oe_n_o[`SSC_PIN_CLK] == ~clk_dir))
        else $error("pin group selection wrong");

    AST_PULSE_ONCE: assert property (
        strobe_pulse |=> !strobe_pulse)
        else $error("strobe pulse longer than one cycle");
endmodule

`default_nettype wire
